// File: pin_sync.sv
// three-stage synchroniser with agreement filter for a group of pins
// assumes asynchronous inputs; output changes once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_flt
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;

	// first stage feeds only the second, so metastability never reaches logic
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stage1_ff <= RESET_VALUE;
			stage2_ff <= RESET_VALUE;
			stage3_ff <= RESET_VALUE;
		end else begin
			stage1_ff <= pin_in;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
		end
	end

	// per-bit agreement filter
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_flt <= RESET_VALUE;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2_ff[i] == stage3_ff[i]) begin
					pin_flt[i] <= stage3_ff[i];
				end
			end
		end
	end
endmodule // pin_sync

// File: spi_eeprom_core.sv
// serial eeprom command core: spi decode, status register, protection, array
// assumes spi pins arrive asynchronously and sck runs well below ref_clk / 8
`timescale 1ns/1ps

// Operation
// RULE1 - busy bit reads 1 during a write; only status read accepted then
// RULE2 - write latch clear blocks all status and array changes; reset clears it
// RULE3 - protect level bits are nonvolatile, shipped zero, survive resets
// RULE4 - level 0 none, 1 top quarter, 2 top half, 3 whole array
// RULE5 - status bits 4 to 6 store nothing and read 0 when idle
// RULE6 - arm bit with protect pin low makes status read-only, array unaffected
// RULE7 - arm bit may fall from 1 to 0 only while protect pin is high
// RULE8 - every status bit reads 1 during an internal write
// RULE9 - sample si on sck rise, drive so on fall, msb first, opcode first
// RULE10 - host raises chip select at a byte boundary to launch an operation
// RULE11 - decode set latch, clear latch, status read, status write ignoring bit 3
// RULE12 - decode array read, array write, id page read and id special opcodes
// RULE13 - id instructions use address bit 10 to pick page data or lock
// RULE14 - host never sends an opcode outside the instruction set
// RULE15 - latch clears after clear-latch, status write or array write completes
// RULE16 - status read repeats the status byte while chip select stays low
// RULE17 - status write keeps level and arm only; needs latch, no hw protect
// RULE18 - status register takes new values only when the write cycle ends
// RULE19 - array read takes 16-bit address, auto-increments, wraps to zero
// RULE20 - array write takes up to 64 bytes in one page, wrapping in page
// RULE21 - protected bytes never change; others need the latch; hw protect ignored
// RULE22 - id page read starts at address bits 5:0 and auto-increments
// RULE23 - host keeps id page reads inside the 64-byte page
// RULE24 - id page read refused while a write cycle runs
// RULE25 - lock status read returns lock flag in bit 0, repeated
// RULE26 - busy set from launching chip select rise until the write cycle ends
module spi_eeprom_core import spi_eeprom_pkg::*; #(
	parameter int WRITE_TIME_CYCLES = WRITE_CYCLES,
	parameter int ARRAY_BYTES = 16384
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic wp_n,
	output logic so,
	output logic so_oe
);
	// ****************************************
	// declarations
	// ****************************************
	logic cs_n_flt;
	logic sck_flt;
	logic si_flt;
	logic wp_n_flt;
	logic sck_q_ff;
	logic cs_q_ff;
	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	logic byte_done;
	logic [7:0] byte_in;
	logic [2:0] bit_ff;
	logic [6:0] shift_ff;
	phase_type phase_ff;
	cmd_type cmd_ff;
	logic [15:0] addr_ff;
	logic load_ff;
	logic [7:0] out_byte_ff;
	logic data_seen_ff;
	logic [7:0] st_data_ff;
	logic latch_ff;
	logic busy_ff;
	logic wkind_status_ff;
	logic [PAGE_BITS:0] commit_idx_ff;
	logic [ADDR_BITS-PAGE_BITS-1:0] page_ff;
	logic [PAGE_BYTES-1:0] mask_ff;
	logic [1:0] protect_level_ff = LEVEL_SHIPPED;
	logic hw_protect_arm_ff = ARM_SHIPPED;
	logic id_lock_ff = LOCK_SHIPPED;
	logic hw_protect;
	logic launch_ok;
	logic start_write;
	logic start_status;
	logic start_array;
	logic timer_done;
	logic commit_we;
	logic [ADDR_BITS-1:0] commit_addr;
	logic [7:0] status_value;
	logic [7:0] read_value;
	logic [7:0] mem [0:ARRAY_BYTES-1] = '{default: 8'h00};
	logic [7:0] pbuf [0:PAGE_BYTES-1];
	logic [7:0] idmem [0:PAGE_BYTES-1] = '{default: 8'h00};

	initial begin
		if (ARRAY_BYTES != (1 << ADDR_BITS) || WRITE_TIME_CYCLES <= PAGE_BYTES) begin
			$error("spi_eeprom_core: unsupported array size or write time");
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ****************************************
	// pin sampling and edge detection
	// ****************************************
	pin_sync #(.WIDTH(4), .RESET_VALUE(PIN_RESET)) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.pin_in({cs_n, sck, si, wp_n}),
		.pin_flt({cs_n_flt, sck_flt, si_flt, wp_n_flt})
	);

	// previous filtered levels for edge finding
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sck_q_ff <= 1'b0;
			cs_q_ff <= 1'b1;
		end else begin
			sck_q_ff <= sck_flt;
			cs_q_ff <= cs_n_flt;
		end
	end

	assign sck_rise = sck_flt & ~sck_q_ff & ~cs_n_flt; // [RULE9]
	assign sck_fall = ~sck_flt & sck_q_ff & ~cs_n_flt; // [RULE9]
	assign cs_rise = cs_n_flt & ~cs_q_ff;
	assign byte_done = sck_rise && (bit_ff == 3'h7);
	assign byte_in = {shift_ff, si_flt}; // msb first [RULE9]
	assign hw_protect = hw_protect_arm_ff & ~wp_n_flt; // [RULE6]

	// ****************************************
	// bit and byte framing
	// ****************************************
	// input shifter; chip select high restarts framing at the opcode
	always_ff @(posedge ref_clk) begin
		if (rst || cs_n_flt) begin
			bit_ff <= 3'h0;
			shift_ff <= 7'h00;
		end else if (sck_rise) begin
			bit_ff <= bit_ff + 3'h1;
			shift_ff <= byte_in[6:0];
		end
	end

	// ****************************************
	// instruction decode and phase sequencing
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst || cs_n_flt) begin
			phase_ff <= PH_OPCODE;
			cmd_ff <= CMD_NONE;
		end else if (byte_done) begin
			case (phase_ff)
				PH_OPCODE: begin
					// while busy anything but a status read is dropped [RULE1] [RULE24]
					if (busy_ff && !op_is(byte_in, OPC_STATUS_READ)) begin
						phase_ff <= PH_IGNORE;
						cmd_ff <= CMD_NONE;
					end else if (op_is(byte_in, OPC_SET_LATCH)) begin // [RULE11]
						phase_ff <= PH_IGNORE;
						cmd_ff <= CMD_SET_LATCH;
					end else if (op_is(byte_in, OPC_CLEAR_LATCH)) begin // [RULE11]
						phase_ff <= PH_IGNORE;
						cmd_ff <= CMD_CLEAR_LATCH;
					end else if (op_is(byte_in, OPC_STATUS_READ)) begin // [RULE11]
						phase_ff <= PH_DATA_OUT;
						cmd_ff <= CMD_STATUS_READ;
					end else if (op_is(byte_in, OPC_STATUS_WRITE)) begin // [RULE11]
						phase_ff <= PH_DATA_IN;
						cmd_ff <= CMD_STATUS_WRITE;
					end else if (op_is(byte_in, OPC_ARRAY_READ)) begin // [RULE12]
						phase_ff <= PH_ADDR_HI;
						cmd_ff <= CMD_ARRAY_READ;
					end else if (op_is(byte_in, OPC_ARRAY_WRITE)) begin // [RULE12]
						phase_ff <= PH_ADDR_HI;
						cmd_ff <= CMD_ARRAY_WRITE;
					end else if (op_is(byte_in, OPC_ID_READ)) begin // [RULE12]
						phase_ff <= PH_ADDR_HI;
						cmd_ff <= CMD_ID_READ;
					end else if (op_is(byte_in, OPC_ID_SPECIAL)) begin // [RULE12]
						phase_ff <= PH_ADDR_HI;
						cmd_ff <= CMD_ID_SPECIAL;
					end else begin
						// unknown opcodes are simply swallowed [RULE14]
						phase_ff <= PH_IGNORE;
						cmd_ff <= CMD_NONE;
					end
				end
				PH_ADDR_HI: phase_ff <= PH_ADDR_LO;
				PH_ADDR_LO: begin
					case (cmd_ff)
						CMD_ARRAY_READ: phase_ff <= PH_DATA_OUT;
						CMD_ARRAY_WRITE: phase_ff <= PH_DATA_IN;
						CMD_ID_READ: begin
							// page data only with the function bit low [RULE13]
							phase_ff <= addr_ff[ID_FUNC_BIT - 8] ? PH_IGNORE : PH_DATA_OUT;
						end
						CMD_ID_SPECIAL: begin
							// lock status with the function bit high; page write is not served [RULE13]
							if (addr_ff[ID_FUNC_BIT - 8]) begin
								phase_ff <= PH_DATA_OUT;
								cmd_ff <= CMD_LOCK_READ;
							end else begin
								phase_ff <= PH_IGNORE;
							end
						end
						default: phase_ff <= PH_IGNORE;
					endcase
				end
				default: phase_ff <= phase_ff;
			endcase
		end
	end

	// ****************************************
	// address register and incoming data
	// ****************************************
	// one pointer serves reads (next byte to fetch) and writes (next buffer slot)
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			addr_ff <= 16'h0000;
		end else if (byte_done && (phase_ff == PH_ADDR_HI || phase_ff == PH_ADDR_LO)) begin
			addr_ff <= {addr_ff[7:0], byte_in};
		end else if (byte_done && phase_ff == PH_DATA_IN && cmd_ff == CMD_ARRAY_WRITE) begin
			addr_ff[PAGE_BITS-1:0] <= addr_ff[PAGE_BITS-1:0] + 6'h01; // in-page wrap [RULE20]
		end else if (load_ff && cmd_ff == CMD_ARRAY_READ) begin
			addr_ff <= addr_ff + 16'h0001; // wraps past the top of the array [RULE19]
		end else if (load_ff && cmd_ff == CMD_ID_READ) begin
			addr_ff[PAGE_BITS-1:0] <= addr_ff[PAGE_BITS-1:0] + 6'h01; // [RULE22]
		end
	end

	// page buffer: later bytes overwrite earlier ones, so the last 64 remain [RULE20]
	always_ff @(posedge ref_clk) begin
		if (byte_done && phase_ff == PH_DATA_IN && cmd_ff == CMD_ARRAY_WRITE) begin
			pbuf[addr_ff[PAGE_BITS-1:0]] <= byte_in;
		end
	end

	// which buffer slots hold data for the coming write
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mask_ff <= '0;
		end else if (byte_done && phase_ff == PH_OPCODE) begin
			mask_ff <= '0;
		end else if (byte_done && phase_ff == PH_DATA_IN && cmd_ff == CMD_ARRAY_WRITE) begin
			mask_ff[addr_ff[PAGE_BITS-1:0]] <= 1'b1;
		end
	end

	// status write data and the at-least-one-data-byte flag
	always_ff @(posedge ref_clk) begin
		if (rst || cs_n_flt) begin
			data_seen_ff <= 1'b0;
		end else if (byte_done && phase_ff == PH_DATA_IN) begin
			data_seen_ff <= 1'b1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_data_ff <= 8'h00;
		end else if (byte_done && phase_ff == PH_DATA_IN && cmd_ff == CMD_STATUS_WRITE) begin
			st_data_ff <= byte_in;
		end
	end

	// ****************************************
	// outgoing data
	// ****************************************
	// during a write all bits read 1; idle bits 4 to 6 read 0 [RULE8] [RULE5] [RULE1]
	assign status_value = busy_ff ? STATUS_BUSY_VALUE :
		{hw_protect_arm_ff, 3'h0, protect_level_ff, latch_ff, 1'b0};

	always_comb begin
		case (cmd_ff)
			CMD_STATUS_READ: read_value = status_value; // [RULE16]
			CMD_ARRAY_READ: read_value = mem[addr_ff[ADDR_BITS-1:0]]; // [RULE19]
			CMD_ID_READ: read_value = idmem[addr_ff[PAGE_BITS-1:0]]; // [RULE22]
			CMD_LOCK_READ: read_value = {7'h00, id_lock_ff}; // [RULE25]
			default: read_value = 8'h00;
		endcase
	end

	// fetch one cycle after a byte boundary; sck is slow so it is ready before the fall
	always_ff @(posedge ref_clk) begin
		if (rst || cs_n_flt) begin
			load_ff <= 1'b0;
			out_byte_ff <= 8'h00;
		end else begin
			load_ff <= byte_done && (phase_ff == PH_DATA_OUT || phase_ff == PH_ADDR_LO ||
				(phase_ff == PH_OPCODE && op_is(byte_in, OPC_STATUS_READ)));
			if (load_ff && phase_ff == PH_DATA_OUT) begin
				out_byte_ff <= read_value;
			end
		end
	end

	// serial output changes on sck fall, msb first; released when deselected [RULE9]
	always_ff @(posedge ref_clk) begin
		if (rst || cs_n_flt) begin
			so <= 1'b0;
			so_oe <= 1'b0;
		end else if (sck_fall && phase_ff == PH_DATA_OUT) begin
			so <= out_byte_ff[3'h7 - bit_ff];
			so_oe <= 1'b1;
		end
	end

	// ****************************************
	// launch on chip select rise, write latch
	// ****************************************
	// operations start only when deselected exactly at a byte boundary [RULE10]
	assign launch_ok = cs_rise && (bit_ff == 3'h0) && !busy_ff;
	assign start_status = launch_ok && cmd_ff == CMD_STATUS_WRITE && data_seen_ff &&
		latch_ff && !hw_protect; // [RULE17] [RULE6]
	assign start_array = launch_ok && cmd_ff == CMD_ARRAY_WRITE && data_seen_ff && latch_ff; // [RULE2]
	assign start_write = start_status | start_array;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			latch_ff <= LATCH_RESET; // [RULE2]
		end else if (timer_done) begin
			latch_ff <= 1'b0; // each modification needs a fresh set [RULE15]
		end else if (launch_ok && cmd_ff == CMD_SET_LATCH) begin
			latch_ff <= 1'b1; // [RULE2]
		end else if (launch_ok && cmd_ff == CMD_CLEAR_LATCH) begin
			latch_ff <= 1'b0; // [RULE15]
		end
	end

	// ****************************************
	// self-timed write cycle
	// ****************************************
	write_cycle_timer #(.CYCLES(WRITE_TIME_CYCLES)) u_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(start_write),
		.done(timer_done)
	);

	// busy spans launch to completion [RULE26] [RULE1]
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			busy_ff <= 1'b0;
			wkind_status_ff <= 1'b0;
			page_ff <= '0;
			commit_idx_ff <= '0;
		end else if (start_write) begin
			busy_ff <= 1'b1;
			wkind_status_ff <= start_status;
			page_ff <= addr_ff[ADDR_BITS-1:PAGE_BITS];
			commit_idx_ff <= '0;
		end else if (timer_done) begin
			busy_ff <= 1'b0;
		end else if (busy_ff && !commit_idx_ff[PAGE_BITS]) begin
			commit_idx_ff <= commit_idx_ff + 7'h01;
		end
	end

	// one buffered byte per cycle; protected bytes are skipped [RULE21] [RULE4]
	assign commit_addr = {page_ff, commit_idx_ff[PAGE_BITS-1:0]};
	assign commit_we = busy_ff && !wkind_status_ff && !commit_idx_ff[PAGE_BITS] &&
		mask_ff[commit_idx_ff[PAGE_BITS-1:0]] && !is_protected(protect_level_ff, commit_addr);

	always_ff @(posedge ref_clk) begin
		if (commit_we) begin
			mem[commit_addr] <= pbuf[commit_idx_ff[PAGE_BITS-1:0]];
		end
	end

	// nonvolatile bits: no reset, updated only at the end of a status write [RULE3] [RULE18]
	always_ff @(posedge ref_clk) begin
		if (!rst && timer_done && wkind_status_ff) begin
			protect_level_ff <= {st_data_ff[ST_LEVEL_HI_BIT], st_data_ff[ST_LEVEL_LO_BIT]}; // [RULE17]
			hw_protect_arm_ff <= st_data_ff[ST_ARM_BIT] | (hw_protect_arm_ff & ~wp_n_flt); // [RULE7]
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	AST_BUSY_ALL_ONES: assert property (load_ff && phase_ff == PH_DATA_OUT && busy_ff && !cs_n_flt |=> // [RULE8]
		out_byte_ff == STATUS_BUSY_VALUE) else $error("status not all ones while busy");
	AST_IDLE_RESERVED_ZERO: assert property (!busy_ff |-> status_value[6:4] == 3'h0 && !status_value[0]) // [RULE5]
		else $error("reserved or busy bit set while idle");
	AST_WRITE_NEEDS_LATCH: assert property ($rose(busy_ff) |-> $past(latch_ff)) // [RULE2]
		else $error("write cycle started without the write latch");
	AST_STATUS_ONLY_AT_END: assert property (!timer_done |=> $stable(protect_level_ff) && $stable(hw_protect_arm_ff)) // [RULE18]
		else $error("status bits changed outside write completion");
	AST_LATCH_CLEARED: assert property ($fell(busy_ff) |-> !latch_ff) // [RULE15]
		else $error("write latch still set after write cycle");
	AST_ARM_FALL_PIN_HIGH: assert property ($fell(hw_protect_arm_ff) |-> $past(wp_n_flt)) // [RULE7]
		else $error("arm bit cleared while protect pin low");
	AST_STATUS_HW_BLOCK: assert property (start_status |-> latch_ff && (wp_n_flt || !hw_protect_arm_ff)) // [RULE17]
		else $error("status write launched under hardware protection");
	AST_NO_PROTECTED_COMMIT: assert property (commit_we |-> protect_level_ff == 2'h0 || // [RULE21]
		(protect_level_ff == 2'h1 && commit_addr < PROT_QUARTER_BASE) ||
		(protect_level_ff == 2'h2 && commit_addr < PROT_HALF_BASE)) else $error("protected array byte written");
	AST_BUSY_HOLDS: assert property ($rose(busy_ff) |-> busy_ff [*8]) // [RULE26]
		else $error("busy dropped early");
	AST_SO_RELEASED: assert property (cs_n_flt |=> !so_oe) // [RULE9]
		else $error("output driven while deselected");
endmodule // spi_eeprom_core

// File: spi_eeprom_pkg.sv
// constants, types and helper functions of the serial eeprom command core
// assumes a single reference clock domain; all pins are sampled into it
package spi_eeprom_pkg;

	// ****************************************
	// array geometry
	// ****************************************
	localparam int ADDR_BITS = 14;
	localparam int PAGE_BITS = 6;
	localparam int PAGE_BYTES = 64;
	localparam int ID_FUNC_BIT = 10;

	// ****************************************
	// opcodes, compared after masking bit 3
	// ****************************************
	localparam logic [7:0] OPC_MASK = 8'hF7;
	localparam logic [7:0] OPC_SET_LATCH = 8'h06;
	localparam logic [7:0] OPC_CLEAR_LATCH = 8'h04;
	localparam logic [7:0] OPC_STATUS_READ = 8'h05;
	localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OPC_ARRAY_READ = 8'h03;
	localparam logic [7:0] OPC_ARRAY_WRITE = 8'h02;
	localparam logic [7:0] OPC_ID_READ = 8'h83;
	localparam logic [7:0] OPC_ID_SPECIAL = 8'h82;

	// ****************************************
	// status register layout and reset values
	// ****************************************
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_LATCH_BIT = 1;
	localparam int ST_LEVEL_LO_BIT = 2;
	localparam int ST_LEVEL_HI_BIT = 3;
	localparam int ST_ARM_BIT = 7;
	localparam logic [7:0] STATUS_BUSY_VALUE = 8'hFF;
	localparam logic LATCH_RESET = 1'b0;
	localparam logic [1:0] LEVEL_SHIPPED = 2'h0;
	localparam logic ARM_SHIPPED = 1'b0;
	localparam logic LOCK_SHIPPED = 1'b0;
	localparam logic [3:0] PIN_RESET = 4'h9;

	// ****************************************
	// protected ranges
	// ****************************************
	localparam logic [ADDR_BITS-1:0] PROT_QUARTER_BASE = 14'h3000;
	localparam logic [ADDR_BITS-1:0] PROT_HALF_BASE = 14'h2000;

	// ****************************************
	// timing: self-timed write, longest time rounds down
	// ****************************************
	localparam longint T_WR_NS = 5000000;
	localparam longint CLK_PERIOD_NS = 10;
	localparam int WRITE_CYCLES = int'(T_WR_NS / CLK_PERIOD_NS);

	typedef enum logic [2:0] {
		PH_OPCODE = 3'b000,
		PH_ADDR_HI = 3'b001,
		PH_ADDR_LO = 3'b010,
		PH_DATA_IN = 3'b011,
		PH_DATA_OUT = 3'b100,
		PH_IGNORE = 3'b101
	} phase_type;

	typedef enum logic [3:0] {
		CMD_NONE = 4'b0000,
		CMD_SET_LATCH = 4'b0001,
		CMD_CLEAR_LATCH = 4'b0010,
		CMD_STATUS_READ = 4'b0011,
		CMD_STATUS_WRITE = 4'b0100,
		CMD_ARRAY_READ = 4'b0101,
		CMD_ARRAY_WRITE = 4'b0110,
		CMD_ID_READ = 4'b0111,
		CMD_ID_SPECIAL = 4'b1000,
		CMD_LOCK_READ = 4'b1001
	} cmd_type;

	// true when the byte at addr lies in the range the protect level covers
	function automatic logic is_protected(input logic [1:0] level, input logic [ADDR_BITS-1:0] addr);
		case (level)
			2'h1: is_protected = (addr >= PROT_QUARTER_BASE);
			2'h2: is_protected = (addr >= PROT_HALF_BASE);
			2'h3: is_protected = 1'b1;
			default: is_protected = 1'b0;
		endcase
	endfunction

	// opcode compare with the don't-care bit removed
	function automatic logic op_is(input logic [7:0] op, input logic [7:0] code);
		op_is = ((op & OPC_MASK) == code);
	endfunction

endpackage

// File: spi_host_model.sv
// spi host model: drives the serial pins of the eeprom core in mode 0
// assumes ref_clk at 100 MHz; sck low 6 or 7 cycles, high 6 (125 ns mean)
`timescale 1ns/1ps
module spi_host_model (
	input wire logic ref_clk,
	input wire logic so,
	input wire logic so_oe,
	output logic cs_n,
	output logic sck,
	output logic si
);
	logic [7:0] rx_q[$];
	// idle: deselected, clock parked low
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b1;
	end
	// one frame: send tx, clock n_rd more bytes in and keep them
	task automatic frame(input logic [7:0] tx[$], input int n_rd);
		logic [7:0] b;
		rx_q.delete();
		@(posedge ref_clk) cs_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < tx.size() + n_rd; i++) begin
			b = (i < tx.size()) ? tx[i] : 8'h00;
			for (int k = 7; k >= 0; k--) begin
				@(posedge ref_clk) sck <= 1'b0;
				si <= b[k];
				repeat (6 + k % 2) @(posedge ref_clk);
				sck <= 1'b1;
				b[k] = so_oe ? so : ~so; // a released line reads back inverted, so refusals show
				repeat (5) @(posedge ref_clk);
			end
			if (i >= tx.size()) rx_q.push_back(b);
		end
		// deselect at a byte boundary, before any further rise
		@(posedge ref_clk) sck <= 1'b0;
		repeat (2) @(posedge ref_clk);
		cs_n <= 1'b1;
		si <= ~si; // released line must not keep its last value
		repeat (8) @(posedge ref_clk);
	endtask
endmodule // spi_host_model

// File: tb_top.sv
// self-checking bench for the serial eeprom command core
// assumes spi_host_model as the host; write time shortened to 2000 cycles
`timescale 1ns/1ps
module tb_top;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic wp_n = 1'b1;
	logic cs_n, sck, si, so, so_oe;
	int bad_count = 0;
	int n_compared = 0;
	// 100 MHz reference clock
	always #5 ref_clk = ~ref_clk;
	spi_eeprom_core #(.WRITE_TIME_CYCLES(2000)) spi_eeprom_core_inst (.ref_clk(ref_clk), .rst(rst),
		.cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe));
	spi_host_model spi_host_model_inst (.ref_clk(ref_clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck),
		.si(si));
	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic fr(input logic [7:0] tx[$], input int n);
		spi_host_model_inst.frame(tx, n);
	endtask
	function automatic logic [7:0] rx(input int i);
		return spi_host_model_inst.rx_q[i];
	endfunction
	// status read with opcode bit 3 set; the byte must repeat
	task automatic status_is(input logic [7:0] exp);
		fr('{8'h0D}, 2);
		check(rx(0), exp);
		check(rx(1), exp);
	endtask
	// poll busy until clear, bounded so a stuck busy shows as a mismatch
	task automatic wait_idle();
		int n = 0;
		do begin
			fr('{8'h05}, 1);
			n++;
		end while (rx(0) !== 8'h00 && rx(0)[0] !== 1'b0 && n < 40);
		check({7'h00, n >= 40}, 8'h00);
	endtask
	// header and data, latch set first when asked
	task automatic send(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d[$], input bit latch);
		if (latch) fr('{8'h06}, 0);
		if (op != 8'h01) begin
			d.push_front(a[7:0]);
			d.push_front(a[15:8]);
		end
		d.push_front(op); // only listed opcodes are ever sent
		fr(d, 0);
	endtask
	task automatic rd(input logic [7:0] op, input logic [15:0] a, input int n);
		fr('{op, a[15:8], a[7:0]}, n);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_latch();
		status_is(8'h00);
		fr('{8'h0E}, 0);
		status_is(8'h02);
		fr('{8'h04}, 0);
		status_is(8'h00);
	endtask
	// busy status, page wrap, array wrap, unlatched write refused
	task automatic t_array();
		send(8'h02, 16'h0000, '{8'hC5}, 1);
		status_is(8'hFF);
		rd(8'h03, 16'h0000, 1);
		check(rx(0), 8'hFF);
		rd(8'h83, 16'h0000, 1);
		check(rx(0), 8'hFF);
		wait_idle();
		send(8'h0A, 16'hFFFF, '{8'h5A, 8'h3C}, 1);
		wait_idle();
		status_is(8'h00);
		rd(8'h03, 16'h3FFF, 2);
		check(rx(0), 8'h5A);
		check(rx(1), 8'hC5);
		rd(8'h03, 16'h3FC0, 1);
		check(rx(0), 8'h3C);
		send(8'h02, 16'h0001, '{8'h77}, 0);
		status_is(8'h00);
		rd(8'h0B, 16'h0001, 1);
		check(rx(0), 8'h00);
	endtask
	// status write, protect levels, hardware protect and arm release
	task automatic t_protect();
		send(8'h01, 16'h0000, '{8'hFC}, 1);
		status_is(8'hFF);
		wait_idle();
		status_is(8'h8C);
		send(8'h02, 16'h0002, '{8'h99}, 1);
		wait_idle();
		rd(8'h03, 16'h0002, 1);
		check(rx(0), 8'h00);
		@(posedge ref_clk) wp_n <= 1'b0;
		send(8'h01, 16'h0000, '{8'h00}, 1);
		status_is(8'h8E);
		@(posedge ref_clk) wp_n <= 1'b1;
		send(8'h01, 16'h0000, '{8'h04}, 0);
		wait_idle();
		status_is(8'h04);
		send(8'h02, 16'h3000, '{8'h11}, 1);
		wait_idle();
		send(8'h02, 16'h2FFF, '{8'h22}, 1);
		wait_idle();
		rd(8'h03, 16'h2FFF, 2);
		check(rx(0), 8'h22);
		check(rx(1), 8'h00);
	endtask
	task automatic t_id();
		rd(8'h83, 16'h0005, 2);
		check(rx(0), 8'h00);
		check(rx(1), 8'h00);
		rd(8'h82, 16'h0400, 2);
		check(rx(0), 8'h00);
		check(rx(1), 8'h00);
		rd(8'h82, 16'h0000, 1);
		check(rx(0), 8'hFF);
		rd(8'h8B, 16'h0400, 1);
		check(rx(0), 8'hFF);
		check({7'h00, so_oe}, 8'h00);
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (8) @(posedge ref_clk);
		t_latch();
		t_array();
		t_protect();
		t_id();
		tally_and_finish();
	end
	// watchdog, well above the expected run length
	initial begin
		repeat (90000) @(posedge ref_clk);
		bad_count++;
		tally_and_finish();
	end
endmodule // tb_top

// File: write_cycle_timer.sv
// self-timed write cycle counter
// assumes start is a one-cycle pulse that never comes while running
`timescale 1ns/1ps
module write_cycle_timer #(
	parameter int CYCLES = 500000
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic start,
	output logic done
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] count_ff;
	logic running_ff;

	initial begin
		if (CYCLES < 2) begin
			$error("write_cycle_timer: CYCLES must be at least 2");
		end
	end

	// count down and pulse done on the last cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count_ff <= '0;
			running_ff <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				count_ff <= CW'(CYCLES - 1);
				running_ff <= 1'b1;
			end else if (running_ff) begin
				count_ff <= count_ff - CW'(1);
				if (count_ff == CW'(1)) begin
					running_ff <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule // write_cycle_timer
